// ==== hdl/spiopt_pkg.sv ====
// Function
// R1: option control register is read and written by software.
// R2: bit 6 of option control is not implemented and reads 0.
// R3: software never writes bit 6 of option control.
// R4: match enable set raises interrupt while match flag is 1, else inhibited.
// R5: transmit dma enable requests dma while transmit empty and enabled.
// R6: transmit dma enable suppresses the transmit-empty interrupt; clear allows it.
// R7: receive dma enable requests dma while receive full and enabled.
// R8: receive dma enable suppresses the receive-full interrupt.
// R9: in slave mode mode-fault enable is ignored; select pin is input.
// R10: master without mode-fault enable releases select pin to general use.
// R11: master with mode-fault enable: select pin fault input or output.
// R12: in bidirectional mode bit 3 enables the shared data pin driver.
// R13: bidirectional shared pin is master-out when master, master-in when slave.
// R14: bidir output enable 0 makes shared pin input, 1 drives it.
// R15: with pin control zero clear, bidir output enable is ignored.
// R16: master fault mode: output enable 0 detects faults, 1 drives select.
// R17: master bidirectional mode leaves master-in pin unused.
// R18: reset clears every option control bit to zero.
package spiopt_pkg;
    typedef logic [2:0] spiopt_addr_t;
    typedef logic [7:0] spiopt_byte_t;

    localparam spiopt_addr_t OFF_MODE = 3'h0;
    localparam spiopt_addr_t OFF_OPT = 3'h1;
    localparam spiopt_addr_t OFF_STAT = 3'h2;
    localparam spiopt_addr_t OFF_MASK = 3'h3;
    localparam spiopt_addr_t OFF_FLAGS = 3'h4;

    // option control fields
    localparam int OPT_MIE = 7;
    localparam int OPT_TXDMA = 5;
    localparam int OPT_MODF = 4;
    localparam int OPT_BIDIR = 3;
    localparam int OPT_RXDMA = 2;
    localparam int OPT_SWAI = 1;
    localparam int OPT_PC0 = 0;
    localparam spiopt_byte_t OPT_WR_MASK = 8'hbf;
    localparam spiopt_byte_t RST_OPT = 8'h00;

    // mode control fields
    localparam int MODE_SPE = 0;
    localparam int MODE_MSTR = 1;
    localparam int MODE_SLAVE_SELECT_OUTPUT_ENABLE = 2;
    localparam spiopt_byte_t MODE_WR_MASK = 8'h07;
    localparam spiopt_byte_t RST_MODE = 8'h00;

    // status and mask fields
    localparam int ST_MODF = 0;
    localparam int ST_SEL = 1;
    localparam int ST_TXE = 2;
    localparam int ST_RXF = 3;
    localparam spiopt_byte_t STAT_MASK = 8'h0f;
    localparam spiopt_byte_t RST_STAT = 8'h00;
    localparam spiopt_byte_t RST_MASK = 8'h00;

    // live flag view
    localparam int FL_TEF = 0;
    localparam int FL_RFF = 1;
    localparam int FL_MATCH = 2;
    localparam int FL_SS = 3;
    localparam int FL_SCK = 4;

    // synchroniser lanes
    localparam int SY_SCK = 3;
    localparam int SY_SS = 2;
    localparam int SY_MOSI = 1;
    localparam int SY_MISO = 0;
    localparam int SY_W = 4;
    // serial clock idles low, the rest idle high: no false edge after reset
    localparam logic [3:0] RST_SYNC = 4'h7;

    typedef enum logic [2:0] {
        SS_OFF = 3'b000,
        SS_SLAVE_IN = 3'b001,
        SS_GPIO = 3'b010,
        SS_FAULT_IN = 3'b011,
        SS_AUTO_OUT = 3'b100
    } spiopt_ss_role_t;
endpackage

// ==== hdl/spiopt_sync.sv ====
`timescale 1ns/1ns
module spiopt_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic [spiopt_pkg::SY_W-1:0] d,
    output logic [spiopt_pkg::SY_W-1:0] q,
    output logic [spiopt_pkg::SY_W-1:0] rise,
    output logic [spiopt_pkg::SY_W-1:0] fall
);
    import spiopt_pkg::*;

    typedef struct packed {
        logic [SY_W-1:0] s1;
        logic [SY_W-1:0] s2;
        logic [SY_W-1:0] s3;
        logic [SY_W-1:0] rise;
        logic [SY_W-1:0] fall;
    } spiopt_sync_st_t;

    spiopt_sync_st_t st_ff;
    spiopt_sync_st_t nxt_st;

    // s1 feeds only s2; edges compare s2 against s3
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.rise = st_ff.s2 & ~st_ff.s3;
        nxt_st.fall = ~st_ff.s2 & st_ff.s3;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '{RST_SYNC, RST_SYNC, RST_SYNC, '0, '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.s3;
    assign rise = st_ff.rise;
    assign fall = st_ff.fall;
endmodule // spiopt_sync

// ==== hdl/spiopt_top.sv ====
`timescale 1ns/1ns
module spiopt_top (
    input wire logic clk,
    input wire logic rst,
    input wire spiopt_pkg::spiopt_addr_t reg_addr,
    input wire spiopt_pkg::spiopt_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output spiopt_pkg::spiopt_byte_t reg_rdata,
    input wire logic transmit_empty_flag,
    input wire logic receive_full_flag,
    input wire logic receive_match_flag,
    input wire logic frame_active,
    input wire logic tx_bit,
    input wire logic sck_gen,
    input wire logic sck_in,
    input wire logic ss_in,
    input wire logic mosi_in,
    input wire logic miso_in,
    output logic sck_out,
    output logic sck_oe,
    output logic ss_out,
    output logic ss_oe,
    output logic mosi_out,
    output logic mosi_oe,
    output logic miso_out,
    output logic miso_oe,
    output logic ss_spi_owned,
    output logic rx_bit,
    output logic sck_rise,
    output logic sck_fall,
    output logic slave_selected,
    output logic mode_fault,
    output logic tx_dma_req,
    output logic rx_dma_req,
    output logic irq
);
    import spiopt_pkg::*;

    typedef struct packed {
        spiopt_byte_t mode;
        spiopt_byte_t opt;
        spiopt_byte_t stat;
        spiopt_byte_t mask;
        spiopt_byte_t rdata;
        logic prev_tef;
        logic prev_rff;
        logic irq;
        logic tx_dma;
        logic rx_dma;
        logic sck_out;
        logic sck_oe;
        logic ss_out;
        logic ss_oe;
        logic mosi_out;
        logic mosi_oe;
        logic miso_out;
        logic miso_oe;
        logic ss_owned;
        logic rx_bit;
        logic sck_rise;
        logic sck_fall;
        logic selected;
    } spiopt_st_t;

    localparam spiopt_st_t RST_ST = '{
        mode: RST_MODE,
        opt: RST_OPT,
        stat: RST_STAT,
        mask: RST_MASK,
        rdata: 8'h00,
        ss_out: 1'b1,
        miso_out: 1'b1,
        mosi_out: 1'b1,
        default: 1'b0
    };

    spiopt_st_t st_ff;
    spiopt_st_t nxt_st;

    logic [SY_W-1:0] pin_q;
    logic [SY_W-1:0] pin_rise;
    logic [SY_W-1:0] pin_fall;

    // select pin role from enable, master, fault enable and output enable
    function automatic spiopt_ss_role_t ss_role(
        input logic system_enable,
        input logic mstr,
        input logic mode_fault_enable,
        input logic slave_select_output_enable
    );
        spiopt_ss_role_t r;
        r = SS_OFF;
        if (!system_enable) begin
            r = SS_OFF;
        // R9: slave ignores fault enable
        end else if (!mstr) begin
            r = SS_SLAVE_IN;
        // R10: released to gpio
        end else if (!mode_fault_enable) begin
            r = SS_GPIO;
        // R11: R16: fault input or output
        end else if (slave_select_output_enable) begin
            r = SS_AUTO_OUT;
        end else begin
            r = SS_FAULT_IN;
        end
        return r;
    endfunction

    // pin inputs arrive unsynchronised from the link
    spiopt_sync u_sync (
        .clk(clk),
        .rst(rst),
        .d({sck_in, ss_in, mosi_in, miso_in}),
        .q(pin_q),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    spiopt_ss_role_t role;
    logic system_enable;
    logic mstr;
    logic bidir;
    logic sel_now;
    logic [7:0] ev;
    logic [7:0] allow;

    always_comb begin
        nxt_st = st_ff;
        system_enable = st_ff.mode[MODE_SPE];
        mstr = st_ff.mode[MODE_MSTR];
        bidir = st_ff.opt[OPT_PC0];
        role = ss_role(system_enable, mstr, st_ff.opt[OPT_MODF],
                       st_ff.mode[MODE_SLAVE_SELECT_OUTPUT_ENABLE]);
        sel_now = (role == SS_SLAVE_IN) && !pin_q[SY_SS];
        ev = 8'h00;
        allow = 8'hff;

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                OFF_MODE: begin
                    nxt_st.mode = reg_wdata & MODE_WR_MASK;
                end
                // R1: R2: R3: bit 6 never stored
                OFF_OPT: begin
                    nxt_st.opt = reg_wdata & OPT_WR_MASK;
                end
                OFF_STAT: begin
                    nxt_st.stat = st_ff.stat & ~reg_wdata;
                end
                OFF_MASK: begin
                    nxt_st.mask = reg_wdata & STAT_MASK;
                end
                default: begin
                    nxt_st.mode = st_ff.mode;
                end
            endcase
        end

        // sticky events; applied after clears so a set wins
        // R16: low select in fault role is a fault
        ev[ST_MODF] = (role == SS_FAULT_IN) && !pin_q[SY_SS];
        ev[ST_SEL] = (role == SS_SLAVE_IN) && pin_fall[SY_SS];
        // R6: no empty event under transmit dma
        ev[ST_TXE] = transmit_empty_flag && !st_ff.prev_tef &&
                     !st_ff.opt[OPT_TXDMA];
        // R8: no full event under receive dma
        ev[ST_RXF] = receive_full_flag && !st_ff.prev_rff &&
                     !st_ff.opt[OPT_RXDMA];
        nxt_st.stat = nxt_st.stat | ev;
        nxt_st.prev_tef = transmit_empty_flag;
        nxt_st.prev_rff = receive_full_flag;

        // R6: R8: dma mode also hides a pending bit
        allow[ST_TXE] = !st_ff.opt[OPT_TXDMA];
        allow[ST_RXF] = !st_ff.opt[OPT_RXDMA];
        // R4: match level gated by its enable
        nxt_st.irq = |(st_ff.stat & st_ff.mask & allow) ||
                     (st_ff.opt[OPT_MIE] && receive_match_flag);

        // R5: transmit dma request
        nxt_st.tx_dma = st_ff.opt[OPT_TXDMA] && transmit_empty_flag &&
                        system_enable;
        // R7: receive dma request
        nxt_st.rx_dma = st_ff.opt[OPT_RXDMA] && receive_full_flag &&
                        system_enable;

        // read data stands one cycle only
        nxt_st.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                OFF_MODE: begin
                    nxt_st.rdata = st_ff.mode;
                end
                // R2: reserved bit reads zero
                OFF_OPT: begin
                    nxt_st.rdata = st_ff.opt & OPT_WR_MASK;
                end
                OFF_STAT: begin
                    nxt_st.rdata = st_ff.stat;
                end
                OFF_MASK: begin
                    nxt_st.rdata = st_ff.mask;
                end
                OFF_FLAGS: begin
                    nxt_st.rdata[FL_TEF] = transmit_empty_flag;
                    nxt_st.rdata[FL_RFF] = receive_full_flag;
                    nxt_st.rdata[FL_MATCH] = receive_match_flag;
                    nxt_st.rdata[FL_SS] = pin_q[SY_SS];
                    nxt_st.rdata[FL_SCK] = pin_q[SY_SCK];
                end
                default: begin
                    nxt_st.rdata = 8'h00;
                end
            endcase
        end

        // serial clock: master drives it, slave samples it
        nxt_st.sck_oe = system_enable && mstr;
        nxt_st.sck_out = sck_gen;
        nxt_st.sck_rise = sel_now && pin_rise[SY_SCK];
        nxt_st.sck_fall = sel_now && pin_fall[SY_SCK];
        nxt_st.selected = sel_now;

        // data pins; idle high when disabled or not used by the mode
        nxt_st.mosi_out = 1'b1;
        nxt_st.miso_out = 1'b1;
        nxt_st.mosi_oe = 1'b0;
        nxt_st.miso_oe = 1'b0;
        nxt_st.rx_bit = 1'b0;
        if (system_enable) begin
            if (!bidir) begin
                // R15: separate pins, bidir enable unused
                if (mstr) begin
                    nxt_st.mosi_out = tx_bit;
                    nxt_st.mosi_oe = 1'b1;
                    nxt_st.rx_bit = pin_q[SY_MISO];
                end else begin
                    // slave drives only while selected
                    nxt_st.miso_out = tx_bit;
                    nxt_st.miso_oe = sel_now;
                    nxt_st.rx_bit = pin_q[SY_MOSI];
                end
            end else if (mstr) begin
                // R12: R13: R14: R17: master uses mosi only
                nxt_st.mosi_out = tx_bit;
                nxt_st.mosi_oe = st_ff.opt[OPT_BIDIR];
                nxt_st.rx_bit = pin_q[SY_MOSI];
            end else begin
                // R12: R13: R14: slave uses miso only
                nxt_st.miso_out = tx_bit;
                nxt_st.miso_oe = st_ff.opt[OPT_BIDIR];
                nxt_st.rx_bit = pin_q[SY_MISO];
            end
        end

        // select pin by role
        nxt_st.ss_out = 1'b1;
        nxt_st.ss_oe = 1'b0;
        nxt_st.ss_owned = 1'b0;
        case (role)
            // R11: R16: automatic select output
            SS_AUTO_OUT: begin
                nxt_st.ss_out = !frame_active;
                nxt_st.ss_oe = 1'b1;
                nxt_st.ss_owned = 1'b1;
            end
            // R9: R16: select used as input
            SS_FAULT_IN, SS_SLAVE_IN: begin
                nxt_st.ss_owned = 1'b1;
            end
            // R10: pin left to general use
            SS_GPIO, SS_OFF: begin
                nxt_st.ss_owned = 1'b0;
            end
            default: begin
                nxt_st.ss_owned = 1'b0;
            end
        endcase
    end

    // R18: reset clears option control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= RST_ST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign sck_out = st_ff.sck_out;
    assign sck_oe = st_ff.sck_oe;
    assign ss_out = st_ff.ss_out;
    assign ss_oe = st_ff.ss_oe;
    assign mosi_out = st_ff.mosi_out;
    assign mosi_oe = st_ff.mosi_oe;
    assign miso_out = st_ff.miso_out;
    assign miso_oe = st_ff.miso_oe;
    assign ss_spi_owned = st_ff.ss_owned;
    assign rx_bit = st_ff.rx_bit;
    assign sck_rise = st_ff.sck_rise;
    assign sck_fall = st_ff.sck_fall;
    assign slave_selected = st_ff.selected;
    assign mode_fault = st_ff.stat[ST_MODF];
    assign tx_dma_req = st_ff.tx_dma;
    assign rx_dma_req = st_ff.rx_dma;
    assign irq = st_ff.irq;
endmodule // spiopt_top

// ==== testbench/spiopt_asserts.sv ====
`timescale 1ns/1ns
module spiopt_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire spiopt_pkg::spiopt_addr_t reg_addr,
    input wire spiopt_pkg::spiopt_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire spiopt_pkg::spiopt_byte_t reg_rdata,
    input wire logic transmit_empty_flag,
    input wire logic receive_match_flag,
    input wire logic frame_active,
    input wire logic ss_out,
    input wire logic ss_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic ss_spi_owned,
    input wire logic tx_dma_req,
    input wire logic rx_dma_req,
    input wire logic irq
);
    import spiopt_pkg::*;
    // shadow copies rebuilt from bus traffic, not read from the design
    spiopt_byte_t opt_ff, mode_ff;
    logic ms, sl, mg, ma, mb;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            opt_ff <= 8'h00;
            mode_ff <= 8'h00;
        end else if (reg_wr && reg_addr == OFF_OPT) begin
            opt_ff <= reg_wdata & OPT_WR_MASK;
        end else if (reg_wr && reg_addr == OFF_MODE) begin
            mode_ff <= reg_wdata & MODE_WR_MASK;
        end
    end
    assign ms = mode_ff[MODE_SPE] && mode_ff[MODE_MSTR];
    assign sl = mode_ff[MODE_SPE] && !mode_ff[MODE_MSTR];
    assign mg = ms && !opt_ff[OPT_MODF];
    assign ma = ms && opt_ff[OPT_MODF] && mode_ff[MODE_SLAVE_SELECT_OUTPUT_ENABLE];
    assign mb = ms && opt_ff[OPT_PC0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_opt_bit_six: assert property ($past(reg_rd) &&
        $past(reg_addr) == OFF_OPT |-> !reg_rdata[6]) else $error("bit 6 set");
    a_match_irq: assert property (opt_ff[OPT_MIE] &&
        receive_match_flag |=> irq) else $error("match irq missing");
    a_tx_dma_req: assert property (opt_ff[OPT_TXDMA] &&
        transmit_empty_flag && mode_ff[MODE_SPE] |=> tx_dma_req)
        else $error("tx dma req missing");
    a_rx_dma_off: assert property (!(opt_ff[OPT_RXDMA] &&
        mode_ff[MODE_SPE]) |=> !rx_dma_req) else $error("rx dma req stray");
    a_slave_ss_in: assert property (sl ##1 sl |->
        !ss_oe && ss_spi_owned) else $error("slave select not input");
    a_gpio_ss: assert property (mg ##1 mg |->
        !ss_spi_owned && !ss_oe) else $error("select pin not released");
    a_auto_ss_out: assert property (ma ##1 ma |-> ss_oe &&
        ss_out == !$past(frame_active)) else $error("auto select wrong");
    a_bidir_oe: assert property (mb ##1 mb |->
        mosi_oe == $past(opt_ff[OPT_BIDIR]) && !miso_oe)
        else $error("shared pin enable wrong");
    cover property (tx_dma_req && !irq);
    cover property (ss_oe && !ss_out);
    cover property (irq);
endmodule // spiopt_asserts

bind spiopt_top spiopt_asserts i_spiopt_asserts (.*);

// ==== testbench/spiopt_far.sv ====
`timescale 1ns/1ns
module spiopt_far (
    input wire logic frame,
    input wire logic ss_low,
    input wire logic ss_out,
    input wire logic ss_oe,
    input wire logic mosi_out,
    input wire logic mosi_oe,
    input wire logic miso_out,
    input wire logic miso_oe,
    output logic sck_in,
    output logic ss_in,
    output logic mosi_in,
    output logic miso_in
);
    logic pat = 1'b0;
    initial sck_in = 1'b0;
    // clock stands still between frames
    always begin
        wait (frame);
        #200 sck_in = 1'b1;
        #200 sck_in = 1'b0;
    end
    // undriven data lines wander so a stale value never passes; an undriven select follows ss_low
    always #50 pat = ~pat;
    assign ss_in = ss_oe ? ss_out : !ss_low;
    assign mosi_in = mosi_oe ? mosi_out : pat;
    assign miso_in = miso_oe ? miso_out : !pat;
endmodule // spiopt_far

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
    import spiopt_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    spiopt_addr_t reg_addr = 3'h0;
    spiopt_byte_t reg_wdata = 8'h00;
    spiopt_byte_t reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, frame = 1'b0, ss_low = 1'b0;
    logic transmit_empty_flag = 1'b0, receive_full_flag = 1'b0;
    logic receive_match_flag = 1'b0, frame_active = 1'b0;
    logic sck_in, ss_in, mosi_in, miso_in, ss_out, ss_oe, mosi_out;
    logic mosi_oe, miso_out, miso_oe, ss_spi_owned, rx_bit, sck_rise;
    logic slave_selected, mode_fault, tx_dma_req, rx_dma_req, irq;
    logic tx_bit = 1'b0, sck_gen = 1'b0, sck_out, sck_oe, sck_fall;
    int n_errors = 0, cmp_count = 0;
    always #25 clk = ~clk;
    spiopt_top i_spiopt_top (.*);
    spiopt_far i_spiopt_far (.*);
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input spiopt_addr_t a, input spiopt_byte_t v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input spiopt_addr_t a, input spiopt_byte_t e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    task automatic setf(input logic rx, input logic v);
        @(posedge clk);
        if (rx) receive_full_flag <= v;
        else transmit_empty_flag <= v;
    endtask
    task automatic conclude;
        $display("mismatches %0d, compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic t_reset;
        rd(OFF_OPT, 8'h00);
        rd(OFF_MODE, 8'h00);
        chk({2'h0, irq, tx_dma_req, rx_dma_req, ss_oe, mosi_oe, miso_oe},
            8'h00);
        $display("reset test done");
    endtask
    task automatic t_regs;
        wr(OFF_OPT, 8'hbf);
        rd(OFF_OPT, 8'hbf);
        wr(OFF_OPT, 8'h00);
        rd(OFF_OPT, 8'h00);
        rd(3'h7, 8'h00);
        $display("register test done");
    endtask
    task automatic t_match;
        @(posedge clk);
        receive_match_flag <= 1'b1;
        tick(3);
        chk(8'(irq), 8'h00);
        wr(OFF_OPT, 8'h80);
        tick(2);
        chk(8'(irq), 8'h01);
        wr(OFF_OPT, 8'h00);
        tick(2);
        chk(8'(irq), 8'h00);
        @(posedge clk);
        receive_match_flag <= 1'b0;
        $display("match test done");
    endtask
    task automatic t_dma(input logic rx);
        spiopt_byte_t sb, ob;
        sb = 8'h01 << (rx ? ST_RXF : ST_TXE);
        ob = 8'h01 << (rx ? OPT_RXDMA : OPT_TXDMA);
        wr(OFF_MODE, 8'h01);
        setf(rx, 1'b1);
        tick(3);
        chk(8'(irq), 8'h00);
        rd(OFF_STAT, sb);
        wr(OFF_MASK, sb);
        tick(2);
        chk(8'(irq), 8'h01);
        setf(rx, 1'b0);
        wr(OFF_STAT, sb);
        tick(2);
        chk({6'h0, irq, rx ? rx_dma_req : tx_dma_req}, 8'h00);
        wr(OFF_OPT, ob);
        setf(rx, 1'b1);
        tick(3);
        chk({6'h0, irq, rx ? rx_dma_req : tx_dma_req}, 8'h01);
        rd(OFF_STAT, 8'h00);
        wr(OFF_MODE, 8'h00);
        tick(2);
        chk(8'(rx ? rx_dma_req : tx_dma_req), 8'h00);
        setf(rx, 1'b0);
        wr(OFF_OPT, 8'h00);
        wr(OFF_MASK, 8'h00);
        $display("dma test done");
    endtask
    task automatic t_ss;
        wr(OFF_OPT, 8'h10);
        wr(OFF_MODE, 8'h01);
        tick(2);
        chk({6'h0, ss_spi_owned, ss_oe}, 8'h02);
        wr(OFF_MODE, 8'h03);
        wr(OFF_OPT, 8'h00);
        tick(2);
        chk({6'h0, ss_spi_owned, ss_oe}, 8'h00);
        wr(OFF_OPT, 8'h10);
        @(posedge clk);
        ss_low <= 1'b1;
        tick(6);
        chk(8'(mode_fault), 8'h01);
        ss_low <= 1'b0;
        tick(4);
        wr(OFF_STAT, 8'h01);
        wr(OFF_MODE, 8'h07);
        @(posedge clk);
        frame_active <= 1'b1;
        tick(2);
        chk({5'h0, mode_fault, ss_oe, ss_out}, 8'h02);
        @(posedge clk);
        frame_active <= 1'b0;
        tick(2);
        chk({5'h0, mode_fault, ss_oe, ss_out}, 8'h03);
        wr(OFF_MODE, 8'h00);
        wr(OFF_OPT, 8'h00);
        $display("select test done");
    endtask
    task automatic t_pins;
        spiopt_byte_t md[4] = '{8'h03, 8'h03, 8'h03, 8'h01};
        spiopt_byte_t op[4] = '{8'h08, 8'h09, 8'h01, 8'h09};
        spiopt_byte_t ex[4] = '{8'h02, 8'h02, 8'h00, 8'h01};
        for (int i = 0; i < 4; i++) begin
            wr(OFF_MODE, md[i]);
            wr(OFF_OPT, op[i]);
            tick(2);
            chk({6'h0, mosi_oe, miso_oe}, ex[i]);
        end
        @(posedge clk);
        tx_bit <= 1'b1;
        tick(6);
        chk({4'h0, sck_oe, miso_out, mosi_out, rx_bit}, 8'h07);
        @(posedge clk);
        tx_bit <= 1'b0;
        tick(6);
        chk({4'h0, sck_oe, miso_out, mosi_out, rx_bit}, 8'h02);
        wr(OFF_MODE, 8'h03);
        @(posedge clk);
        sck_gen <= 1'b1;
        tick(2);
        chk({5'h0, sck_oe, sck_out, mosi_out}, 8'h06);
        @(posedge clk);
        sck_gen <= 1'b0;
        wr(OFF_OPT, 8'h00);
        $display("pin test done");
    endtask
    task automatic t_link;
        int n;
        int m;
        n = 0;
        m = 0;
        wr(OFF_MODE, 8'h01);
        @(posedge clk);
        ss_low <= 1'b1;
        tick(6);
        chk(8'(slave_selected), 8'h01);
        frame <= 1'b1;
        // stop between the eighth rise and its fall
        for (int i = 0; i < 72; i++) begin
            tick(1);
            n += int'(sck_rise);
            m += int'(sck_fall);
            if (i == 62) frame <= 1'b0;
        end
        chk(8'(n), 8'h08);
        chk(8'(m), 8'h08);
        ss_low <= 1'b0;
        $display("link test done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_match();
        t_dma(1'b0);
        t_dma(1'b1);
        t_ss();
        t_pins();
        t_link();
        conclude();
    end
endmodule // tb_top
